//--- src/dim_image_map.sv
// Functional notes
// - Sixteen inputs: channels 1-8 in bits 0-7, channels 9-16 in bits 8-15.
// - Every output channel follows exactly one control bit of the output image.
// - Diagnostic bits of output modules appear in the input image only.
// - Single output uses bit 0, ignores bit 1, returns manual flag in bit 0.
// - Plain dual output: channel 1 from bit 0, channel 2 from bit 1.
// - Single-flag diagnostic sets on overload, short circuit or broken wire.
// - Dual single-flag diagnostic: channel 1 flag bit 0, channel 2 bit 1.
// - Coded variant gives each channel a two-bit fault code.
// - Channel 1 code in bits 1:0, channel 2 in bits 3:2.
// - Code 00 normal, 01 open load or short to supply, 10 short to ground.
// - Quad output: channels 1-4 from bits 0-3.
`default_nettype none
module dim_image_map
   import dim_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [IN16_W-1:0] input_channel_bit,
   output logic [IN16_W-1:0] in16_img_r,
   input wire logic [IMG_BYTE_W-1:0] s1_out_img,
   input wire logic s1_manual,
   output logic s1_chan_r,
   output logic [IMG_BYTE_W-1:0] s1_in_img_r,
   input wire logic [IMG_BYTE_W-1:0] p2_out_img,
   output logic [CH_DUAL-1:0] p2_chan_r,
   input wire logic [IMG_BYTE_W-1:0] f2_out_img,
   input wire logic [CH_DUAL-1:0] f2_overload,
   input wire logic [CH_DUAL-1:0] f2_short,
   input wire logic [CH_DUAL-1:0] f2_wire_break,
   output logic [CH_DUAL-1:0] f2_chan_r,
   output logic [IMG_BYTE_W-1:0] f2_in_img_r,
   input wire logic [IMG_BYTE_W-1:0] c2_out_img,
   input wire logic [CH_DUAL-1:0] c2_open_load,
   input wire logic [CH_DUAL-1:0] c2_short_gnd,
   output logic [CH_DUAL-1:0] c2_chan_r,
   output logic [IMG_BYTE_W-1:0] c2_in_img_r,
   input wire logic [IMG_BYTE_W-1:0] q4_out_img,
   output logic [CH_QUAD-1:0] q4_chan_r
);
   // ***************************************
   // Sixteen channel input image
   // ***************************************
   // byte split of inputs
   wire logic [IN16_W-1:0] in16_img_nxt = {input_channel_bit[IN16_HI_LSB +: 8],
                                           input_channel_bit[IN16_LO_LSB +: 8]};

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         in16_img_r <= WORD_RESET;
      end else begin
         in16_img_r <= in16_img_nxt;
      end
   end

   // ***************************************
   // Single output with manual flag
   // ***************************************
   // manual flag bit 0
   wire logic [IMG_BYTE_W-1:0] s1_in_img_nxt = {7'h00, s1_manual};

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s1_in_img_r <= BYTE_RESET;
      end else begin
         s1_in_img_r <= s1_in_img_nxt;
      end
   end

   wire logic [CH_SINGLE-1:0] s1_chan_vec;

   dim_out_map #(.N_CH(CH_SINGLE)) u_s1 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .out_img(s1_out_img),
      .chan_r(s1_chan_vec)
   );

   // Direct wire of a flop output
   assign s1_chan_r = s1_chan_vec[0];

   // ***************************************
   // Plain dual and quad outputs
   // ***************************************
   // dual channel map
   dim_out_map #(.N_CH(CH_DUAL)) u_p2 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .out_img(p2_out_img),
      .chan_r(p2_chan_r)
   );

   dim_out_map #(.N_CH(CH_QUAD)) u_q4 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .out_img(q4_out_img),
      .chan_r(q4_chan_r)
   );

   // ***************************************
   // Dual output with one flag per channel
   // ***************************************
   // any fault raises flag
   wire logic [CH_DUAL-1:0] f2_flag = f2_overload | f2_short | f2_wire_break;
   wire logic [IMG_BYTE_W-1:0] f2_in_img_nxt = {6'h00, f2_flag};

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         f2_in_img_r <= BYTE_RESET;
      end else begin
         f2_in_img_r <= f2_in_img_nxt;
      end
   end

   dim_out_map #(.N_CH(CH_DUAL)) u_f2 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .out_img(f2_out_img),
      .chan_r(f2_chan_r)
   );

   // ***************************************
   // Dual output with two-bit codes
   // ***************************************
   // code encoding
   // Ground short is the harder fault, so it wins; 11 is never sent
   wire logic [CODE_W-1:0] c2_code1 = c2_short_gnd[0] ? CODE_SHORT_GND :
                                      c2_open_load[0] ? CODE_OPEN_LOAD : CODE_NORMAL;
   wire logic [CODE_W-1:0] c2_code2 = c2_short_gnd[1] ? CODE_SHORT_GND :
                                      c2_open_load[1] ? CODE_OPEN_LOAD : CODE_NORMAL;
   wire logic [IMG_BYTE_W-1:0] c2_in_img_nxt = {4'h0, c2_code2, c2_code1};

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         c2_in_img_r <= BYTE_RESET;
      end else begin
         c2_in_img_r <= c2_in_img_nxt;
      end
   end

   dim_out_map #(.N_CH(CH_DUAL)) u_c2 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .out_img(c2_out_img),
      .chan_r(c2_chan_r)
   );

   // ***************************************
   // Checks
   // ***************************************
   in16_byte_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> (in16_img_r[15:8] == $past(input_channel_bit[15:8])) &&
                       (in16_img_r[7:0] == $past(input_channel_bit[7:0])))
      else $error("sixteen channel image misplaced");
   manual_flag_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> s1_in_img_r == {7'h00, $past(s1_manual)})
      else $error("manual flag wrong");
   single_ch_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> s1_chan_r == $past(s1_out_img[0]))
      else $error("single channel not from bit 0");
   flag_fault_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> f2_in_img_r[1:0] ==
         $past(f2_overload | f2_short | f2_wire_break))
      else $error("fault flag wrong");
   flag_upper_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      f2_in_img_r[7:2] == 6'h00 && c2_in_img_r[7:4] == 4'h0 && s1_in_img_r[7:1] == 7'h00)
      else $error("unused input bits not zero");
   code_normal_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (c2_short_gnd == 2'h0 && c2_open_load == 2'h0) |=> c2_in_img_r[3:0] == 4'h0)
      else $error("code not normal");
   code_ch2_gnd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      c2_short_gnd[1] |=> c2_in_img_r[3:2] == 2'h2)
      else $error("channel 2 code misplaced");
   code_ch1_open_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (c2_open_load[0] && !c2_short_gnd[0]) |=> c2_in_img_r[1:0] == 2'h1)
      else $error("channel 1 open load code wrong");
   quad_ch_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> q4_chan_r == $past(q4_out_img[3:0]))
      else $error("quad channels misplaced");

   // ***************************************
   // Input image per bit
   // ***************************************
   in16_ch1_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> in16_img_r[0] == $past(input_channel_bit[0]))
      else $error("channel 1 not in bit 0");

   in16_ch8_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> in16_img_r[7] == $past(input_channel_bit[7]))
      else $error("channel 8 not in bit 7");

   in16_ch9_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> in16_img_r[8] == $past(input_channel_bit[8]))
      else $error("channel 9 not in bit 8");

   in16_ch16_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> in16_img_r[15] == $past(input_channel_bit[15]))
      else $error("channel 16 not in bit 15");

   in16_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ($past(rst_n) && $stable(input_channel_bit)) |=> $stable(in16_img_r))
      else $error("input image moved without an input change");

   // ***************************************
   // Output channel controls
   // ***************************************
   plain_dual_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> p2_chan_r == $past(p2_out_img[1:0]))
      else $error("plain dual channels misplaced");

   plain_ch2_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> p2_chan_r[1] == $past(p2_out_img[1]))
      else $error("plain channel 2 not from bit 1");

   diag_dual_ctrl_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> f2_chan_r == $past(f2_out_img[1:0]))
      else $error("flag module controls misplaced");

   coded_dual_ctrl_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> c2_chan_r == $past(c2_out_img[1:0]))
      else $error("coded module controls misplaced");

   coded_ctrl_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ($past(rst_n) && $stable(c2_out_img[1:0])) |=> $stable(c2_chan_r))
      else $error("unused coded output bit changed a channel");

   single_bit1_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ($past(rst_n) && $stable(s1_out_img[0])) |=> $stable(s1_chan_r))
      else $error("single channel moved by an ignored bit");

   quad_ch1_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> q4_chan_r[0] == $past(q4_out_img[0]))
      else $error("quad channel 1 not from bit 0");

   quad_ch4_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> q4_chan_r[3] == $past(q4_out_img[3]))
      else $error("quad channel 4 not from bit 3");

   // ***************************************
   // Single flag diagnostics
   // ***************************************
   flag_ch1_place_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> f2_in_img_r[0] == $past(f2_overload[0] | f2_short[0] | f2_wire_break[0]))
      else $error("channel 1 flag not in bit 0");

   flag_ch2_place_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> f2_in_img_r[1] == $past(f2_overload[1] | f2_short[1] | f2_wire_break[1]))
      else $error("channel 2 flag not in bit 1");

   flag_overload_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      f2_overload[0] |=> f2_in_img_r[0])
      else $error("overload did not raise flag");

   flag_short_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      f2_short[1] |=> f2_in_img_r[1])
      else $error("short circuit did not raise flag");

   flag_break_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      f2_wire_break[0] |=> f2_in_img_r[0])
      else $error("broken wire did not raise flag");

   flag_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (f2_overload == 2'h0 && f2_short == 2'h0 && f2_wire_break == 2'h0) |=> f2_in_img_r == BYTE_RESET)
      else $error("flag set without a fault");

   diag_not_ctrl_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ($past(rst_n) && $stable(f2_out_img[1:0])) |=> $stable(f2_chan_r))
      else $error("diagnostics leaked into the channel controls");

   // ***************************************
   // Coded diagnostics and manual flag
   // ***************************************
   code_ch1_gnd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      c2_short_gnd[0] |=> c2_in_img_r[1:0] == CODE_SHORT_GND)
      else $error("channel 1 ground code wrong");

   code_ch2_open_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (c2_open_load[1] && !c2_short_gnd[1]) |=> c2_in_img_r[3:2] == CODE_OPEN_LOAD)
      else $error("channel 2 open load code wrong");

   code_ch1_normal_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!c2_open_load[0] && !c2_short_gnd[0]) |=> c2_in_img_r[1:0] == CODE_NORMAL)
      else $error("channel 1 code not normal");

   code_ch2_normal_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!c2_open_load[1] && !c2_short_gnd[1]) |=> c2_in_img_r[3:2] == CODE_NORMAL)
      else $error("channel 2 code not normal");

   code_never_three_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      c2_in_img_r[1:0] != 2'h3 && c2_in_img_r[3:2] != 2'h3)
      else $error("undefined fault code");

   manual_bit_place_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> s1_in_img_r[MANUAL_BIT] == $past(s1_manual))
      else $error("manual flag not in bit 0");
endmodule : dim_image_map
`default_nettype wire

//--- src/dim_pkg.sv
`default_nettype none
package dim_pkg;
   // ***************************************
   // Image geometry
   // ***************************************
   localparam int IMG_BYTE_W = 8;
   localparam int IN16_W = 16;
   localparam int IN16_LO_LSB = 0;
   localparam int IN16_HI_LSB = 8;
   localparam int CH_SINGLE = 1;
   localparam int CH_DUAL = 2;
   localparam int CH_QUAD = 4;
   // ***************************************
   // Bit positions
   // ***************************************
   localparam int MANUAL_BIT = 0;
   localparam int CODE_W = 2;
   localparam int CODE_CH1_LSB = 0;
   localparam int CODE_CH2_LSB = 2;
   // ***************************************
   // Fault codes and reset values
   // ***************************************
   localparam logic [1:0] CODE_NORMAL = 2'h0;
   localparam logic [1:0] CODE_OPEN_LOAD = 2'h1;
   localparam logic [1:0] CODE_SHORT_GND = 2'h2;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;
endpackage : dim_pkg
`default_nettype wire

//--- src/dim_out_map.sv
`default_nettype none
module dim_out_map
   import dim_pkg::*;
#(
   parameter int N_CH = 2
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [IMG_BYTE_W-1:0] out_img,
   output logic [N_CH-1:0] chan_r
);
   // ***************************************
   // Channel control
   // ***************************************
   // upper bits ignored
   wire logic [N_CH-1:0] chan_nxt = out_img[N_CH-1:0];

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         chan_r <= BYTE_RESET[N_CH-1:0];
      end else begin
         chan_r <= chan_nxt;
      end
   end

   // ***************************************
   // Checks
   // ***************************************
   ctrl_bit_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> chan_r == $past(out_img[N_CH-1:0]))
      else $error("channel does not follow its control bit");
   unused_bits_ignored_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ($past(rst_n) && $stable(out_img[N_CH-1:0])) |=> $stable(chan_r))
      else $error("unused output bit changed a channel");
endmodule : dim_out_map
`default_nettype wire

//--- tb/dim_ctrl_model.sv
`default_nettype none
module dim_ctrl_model
   import dim_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [IMG_BYTE_W-1:0] img_req,
   output logic [IMG_BYTE_W-1:0] out_img
);
   timeunit 1ns;
   timeprecision 1ps;
   // whole byte
   // Taken on the block's own edge, so the request never races the stimulus
   always @(posedge sys_clk) begin
      out_img <= img_req;
   end
endmodule : dim_ctrl_model
`default_nettype wire

//--- tb/dim_image_map_tb_top.sv
`default_nettype none
module dim_image_map_tb_top
   import dim_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, rst_n = 1'b0, man = 1'b0, s1c;
   logic [15:0] din = 16'h0000, in16;
   logic [7:0] img_req = 8'h00, img, s1i, f2i, c2i;
   logic [1:0] ovl = 2'h0, sht = 2'h0, wbr = 2'h0, opn = 2'h0, gnd = 2'h0, p2c, f2c, c2c;
   logic [3:0] q4c;
   int err_total = 0, total_checks = 0;
   always #4 sys_clk = ~sys_clk;
   dim_ctrl_model ctrl_u (.sys_clk(sys_clk), .img_req(img_req), .out_img(img));
   dim_image_map dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .input_channel_bit(din), .in16_img_r(in16),
      .s1_out_img(img), .s1_manual(man), .s1_chan_r(s1c), .s1_in_img_r(s1i), .p2_out_img(img),
      .p2_chan_r(p2c), .f2_out_img(img), .f2_overload(ovl), .f2_short(sht), .f2_wire_break(wbr),
      .f2_chan_r(f2c), .f2_in_img_r(f2i), .c2_out_img(img), .c2_open_load(opn), .c2_short_gnd(gnd),
      .c2_chan_r(c2c), .c2_in_img_r(c2i), .q4_out_img(img), .q4_chan_r(q4c));
   // ***************************************
   // Shared helpers
   // ***************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk
   // Partner needs one extra edge, so wait three
   task automatic settle;
      repeat (3) @(negedge sys_clk);
   endtask : settle
   task automatic complete_run;
      if (err_total == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : complete_run
   // ***************************************
   // Scenarios
   // ***************************************
   task automatic t_reset;
      din = 16'hFFFF;
      img_req = 8'hFF;
      man = 1'b1;
      sht = 2'h3;
      gnd = 2'h3;
      repeat (12) @(negedge sys_clk);
      chk(32'({in16, s1i, c2i}), 32'h0);
      chk(32'({f2i, p2c, f2c, c2c, q4c, s1c}), 32'h0);
      din = 16'h0000;
      img_req = 8'h00;
      man = 1'b0;
      sht = 2'h0;
      gnd = 2'h0;
      rst_n = 1'b1;
      settle();
   endtask : t_reset
   task automatic t_in16;
      logic [15:0] pat [3] = '{16'h0001, 16'h8000, 16'hA5C3};
      foreach (pat[i]) begin
         din = pat[i];
         settle();
         chk(32'(in16), 32'(pat[i]));
      end
   endtask : t_in16
   task automatic t_outs;
      logic [7:0] pat [5] = '{8'hFF, 8'h02, 8'hFC, 8'h05, 8'hF9};
      foreach (pat[i]) begin
         img_req = pat[i];
         settle();
         chk(32'({p2c, f2c, c2c, q4c, s1c}),
             32'({pat[i][1:0], pat[i][1:0], pat[i][1:0], pat[i][3:0], pat[i][0]}));
      end
   endtask : t_outs
   task automatic t_diag;
      for (int ch = 0; ch < 2; ch++) begin
         for (int k = 0; k < 3; k++) begin
            ovl = (k == 0) ? 2'h1 << ch : 2'h0;
            sht = (k == 1) ? 2'h1 << ch : 2'h0;
            wbr = (k == 2) ? 2'h1 << ch : 2'h0;
            settle();
            chk(32'(f2i), 32'(8'h01 << ch));
            chk(32'(f2c), 32'(img_req[1:0]));
         end
      end
      {ovl, sht, wbr} = 6'h00;
      settle();
      chk(32'(f2i), 32'h0);
   endtask : t_diag
   task automatic t_code;
      logic [11:0] tab [5] = '{{2'h1, 2'h0, 8'h01}, {2'h0, 2'h2, 8'h08}, {2'h1, 2'h1, 8'h02},
         {2'h2, 2'h1, 8'h06}, {2'h0, 2'h0, 8'h00}};
      foreach (tab[i]) begin
         {opn, gnd} = tab[i][11:8];
         settle();
         chk(32'(c2i), 32'(tab[i][7:0]));
      end
   endtask : t_code
   task automatic t_manual;
      man = 1'b1;
      img_req = 8'h02;
      settle();
      chk(32'({s1i, 7'h00, s1c}), 32'h0100);
      man = 1'b0;
      settle();
      chk(32'(s1i), 32'h0);
   endtask : t_manual
   initial begin
      t_reset();
      t_in16();
      t_outs();
      t_diag();
      t_code();
      t_manual();
      complete_run();
   end
endmodule : dim_image_map_tb_top
`default_nettype wire
